//--- common/xace_pkg.sv
package xace_pkg;

   localparam logic [7:0] OP_SET_AXIS_PARAM_INDEXED     = 8'h10;
   localparam logic [7:0] OP_GET_AXIS_PARAM_INDEXED     = 8'h11;
   localparam logic [7:0] OP_ACCU_TO_AXIS_PARAM_INDEXED = 8'h12;
   localparam logic [7:0] OP_ROTATE_RIGHT_INDEXED       = 8'h35;
   localparam logic [7:0] OP_SOFT_STOP_INDEXED          = 8'h36;

   localparam logic [7:0] PAR_ACT_POS       = 8'h01;
   localparam logic [7:0] PAR_TARGET_VEL    = 8'h02;
   localparam logic [7:0] PAR_MAX_POS_SPEED = 8'h04;

   localparam logic [7:0] ST_OK           = 8'h64;
   localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
   localparam logic [7:0] ST_BAD_CMD      = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE     = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE    = 8'h04;

   localparam logic [3:0] POS_ADDR   = 4'h0;
   localparam logic [3:0] POS_OP     = 4'h1;
   localparam logic [3:0] POS_TYPE   = 4'h2;
   localparam logic [3:0] POS_BANK   = 4'h3;
   localparam logic [3:0] FRAME_LAST = 4'h8;

   localparam logic [7:0] REG_ACCU      = 8'h00;
   localparam logic [7:0] REG_XREG      = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_CMD_COUNT = 8'h0c;
   localparam logic [7:0] REG_CTRL      = 8'h10;

   localparam int CTRL_ABORT_BIT     = 0;
   localparam int STATUS_LAST_ST_LSB = 0;
   localparam int STATUS_LAST_OP_LSB = 8;
   localparam int STATUS_FSM_LSB     = 16;

   localparam logic [31:0] ACCU_RST      = 32'h0;
   localparam logic [31:0] XREG_RST      = 32'h0;
   localparam logic [31:0] PARAM_RST     = 32'h0;
   localparam logic [15:0] CMD_COUNT_RST = 16'h0;
   localparam logic [7:0]  MODULE_ADDR_RST = 8'h01;

   typedef enum logic [1:0] {
      FSM_RECV  = 2'b00,
      FSM_EXEC  = 2'b01,
      FSM_REPLY = 2'b10
   } xace_fsm_t;

endpackage : xace_pkg

//--- common/xace_param_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xace_param_if #(
   parameter int NUM_AXES   = 3,
   parameter int NUM_PARAMS = 16
);
   localparam int AW = $clog2(NUM_AXES);
   localparam int PW = $clog2(NUM_PARAMS);
   logic          wr_en;
   logic [AW-1:0] wr_axis;
   logic [PW-1:0] wr_idx;
   logic [31:0]   wr_data;
   logic [AW-1:0] rd_axis;
   logic [PW-1:0] rd_idx;
   logic [31:0]   rd_data;
   modport exec  (output wr_en, wr_axis, wr_idx, wr_data, rd_axis, rd_idx, input rd_data);
   modport store (input wr_en, wr_axis, wr_idx, wr_data, rd_axis, rd_idx, output rd_data);
endinterface : xace_param_if
`default_nettype wire

//--- hw/xace_param_store.sv
`timescale 1ns/1ps
`default_nettype none
module xace_param_store
   import xace_pkg::*;
#(
   parameter int NUM_AXES   = 3,
   parameter int NUM_PARAMS = 16
) (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic [NUM_AXES*32-1:0] act_pos,
   xace_param_if.store                pif
);
   localparam int PW = $clog2(NUM_PARAMS);

   typedef struct packed {
      logic [NUM_AXES-1:0][NUM_PARAMS-1:0][31:0] mem;
   } xace_store_t;

   xace_store_t st_ff;
   xace_store_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (pif.wr_en && (32'(pif.wr_axis) < NUM_AXES)) begin
         nxt_st.mem[pif.wr_axis][pif.wr_idx] = pif.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff.mem <= {(NUM_AXES*NUM_PARAMS){PARAM_RST}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Position lives in the ramp generator; the stored copy only shadows writes
   // live position
   assign pif.rd_data = (32'(pif.rd_axis) >= NUM_AXES) ? 32'h0 :
                        (pif.rd_idx == PAR_ACT_POS[PW-1:0]) ? act_pos[pif.rd_axis*32 +: 32] :
                        st_ff.mem[pif.rd_axis][pif.rd_idx];

   property p_max_speed_store;
      @(posedge clk) disable iff (reset)
      pif.wr_en && pif.wr_idx == PAR_MAX_POS_SPEED[PW-1:0] && 32'(pif.wr_axis) < NUM_AXES
      |=> st_ff.mem[$past(pif.wr_axis)][PAR_MAX_POS_SPEED[PW-1:0]] == $past(pif.wr_data);
   endproperty
   a_max_speed_store: assert property (p_max_speed_store)
      else $error("max speed parameter not stored");
endmodule : xace_param_store
`default_nettype wire

//--- hw/xace_cmd_exec.sv
`timescale 1ns/1ps
`default_nettype none
module xace_cmd_exec
   import xace_pkg::*;
#(
   parameter int         NUM_AXES    = 3,
   parameter int         NUM_PARAMS  = 16,
   parameter logic [7:0] MODULE_ADDR = MODULE_ADDR_RST
) (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         rx_valid,
   input  wire logic [7:0]                   rx_byte,
   output logic                              rx_ready,
   output logic                              reply_valid,
   output logic [7:0]                        reply_status,
   output logic [7:0]                        reply_opcode,
   output logic [31:0]                       reply_value,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [31:0]                       reg_rdata,
   input  wire logic [NUM_AXES*32-1:0]       act_pos,
   output logic                              mc_update,
   output logic [$clog2(NUM_AXES)-1:0]       mc_axis,
   output logic [$clog2(NUM_PARAMS)-1:0]     mc_param,
   output logic [31:0]                       mc_data,
   output logic [NUM_AXES-1:0]               axis_vel_mode,
   output logic [NUM_AXES-1:0]               axis_dir_up
);
   localparam int AW = $clog2(NUM_AXES);
   localparam int PW = $clog2(NUM_PARAMS);
   localparam logic [31:0] NA32 = 32'(NUM_AXES);
   localparam logic [7:0]  NP8  = 8'(NUM_PARAMS);

   typedef struct packed {
      xace_fsm_t             fsm;
      logic [3:0]            cnt;
      logic [7:0]            sum;
      logic [7:0]            f_addr;
      logic [7:0]            f_op;
      logic [7:0]            f_type;
      logic [31:0]           f_val;
      logic                  csum_ok;
      logic [31:0]           accu;
      logic [31:0]           xreg;
      logic [7:0]            last_status;
      logic [15:0]           cmd_cnt;
      logic                  rx_ready;
      logic                  reply_valid;
      logic [7:0]            reply_status;
      logic [7:0]            reply_op;
      logic [31:0]           reply_value;
      logic [31:0]           rdata;
      logic                  mc_update;
      logic [AW-1:0]         mc_axis;
      logic [PW-1:0]         mc_param;
      logic [31:0]           mc_data;
      logic [NUM_AXES-1:0]   vel_mode;
      logic [NUM_AXES-1:0]   dir_up;
   } xace_state_t;

   xace_state_t st_ff;
   xace_state_t nxt_st;
   logic [7:0]  exec_status;
   logic [AW-1:0] x_axis;

   xace_param_if #(.NUM_AXES(NUM_AXES), .NUM_PARAMS(NUM_PARAMS)) pif ();

   xace_param_store #(
      .NUM_AXES   (NUM_AXES),
      .NUM_PARAMS (NUM_PARAMS)
   ) u_store (
      .clk     (clk),
      .reset   (reset),
      .act_pos (act_pos),
      .pif     (pif)
   );

   function automatic logic axis_ok(input logic [31:0] x);
      axis_ok = (x < NA32);
   endfunction : axis_ok

   function automatic logic [31:0] axis_pos(input logic [NUM_AXES*32-1:0] v,
                                            input logic [AW-1:0] a);
      axis_pos = v[a*32 +: 32];
   endfunction : axis_pos
   assign x_axis      = st_ff.xreg[AW-1:0];
   assign pif.rd_axis = x_axis;
   assign pif.rd_idx  = st_ff.f_type[PW-1:0];

   always_comb begin
      nxt_st       = st_ff;
      exec_status  = ST_OK;
      nxt_st.mc_update   = 1'b0;
      nxt_st.reply_valid = 1'b0;
      nxt_st.rdata       = 32'h0;
      pif.wr_en   = 1'b0;
      pif.wr_axis = x_axis;
      pif.wr_idx  = st_ff.f_type[PW-1:0];
      pif.wr_data = st_ff.f_val;
      // Software writes first, so a command result in the same cycle wins
      if (reg_wr) begin
         case (reg_addr)
            REG_ACCU: begin
               nxt_st.accu = reg_wdata;
            end
            REG_XREG: begin
               nxt_st.xreg = reg_wdata;
            end
            default: begin
            end
         endcase
      end
      case (st_ff.fsm)
         FSM_RECV: begin
            if (rx_valid) begin
               nxt_st.cnt = st_ff.cnt + 4'h1;
               nxt_st.sum = st_ff.sum + rx_byte;
               case (st_ff.cnt)
                  POS_ADDR: begin
                     nxt_st.f_addr = rx_byte;
                  end
                  POS_OP: begin
                     nxt_st.f_op = rx_byte;
                  end
                  POS_TYPE: begin
                     nxt_st.f_type = rx_byte;
                  end
                  POS_BANK: begin
                  end
                  FRAME_LAST: begin
                  end
                  default: begin
                     nxt_st.f_val = {st_ff.f_val[23:0], rx_byte};
                  end
               endcase
               if (st_ff.cnt == FRAME_LAST) begin
                  nxt_st.cnt = 4'h0;
                  nxt_st.sum = 8'h0;
                  nxt_st.csum_ok = (rx_byte == st_ff.sum);
                  // Frames for other modules are dropped without a reply
                  nxt_st.fsm = (st_ff.f_addr == MODULE_ADDR) ? FSM_EXEC : FSM_RECV;
               end
            end
         end
         FSM_EXEC: begin
            nxt_st.fsm = FSM_REPLY;
            if (!st_ff.csum_ok) begin
               exec_status = ST_BAD_CHECKSUM;
            end else begin
               case (st_ff.f_op)
                  OP_ROTATE_RIGHT_INDEXED, OP_SOFT_STOP_INDEXED: begin
                     if (!axis_ok(st_ff.xreg)) begin
                        exec_status = ST_BAD_VALUE;
                     end else begin
                        pif.wr_en  = 1'b1;
                        pif.wr_idx = PAR_TARGET_VEL[PW-1:0];
                        nxt_st.vel_mode[x_axis] = 1'b1;
                        if (st_ff.f_op == OP_ROTATE_RIGHT_INDEXED) begin
                           pif.wr_data = st_ff.accu;
                           nxt_st.dir_up[x_axis] = 1'b1;
                        end else begin
                           pif.wr_data = 32'h0;
                        end
                     end
                  end
                  OP_SET_AXIS_PARAM_INDEXED, OP_ACCU_TO_AXIS_PARAM_INDEXED,
                  OP_GET_AXIS_PARAM_INDEXED: begin
                     if (!axis_ok(st_ff.xreg)) begin
                        exec_status = ST_BAD_VALUE;
                     end else if (st_ff.f_type >= NP8) begin
                        exec_status = ST_BAD_TYPE;
                     end else if (st_ff.f_op == OP_GET_AXIS_PARAM_INDEXED) begin
                        nxt_st.accu        = pif.rd_data;
                        nxt_st.reply_value = pif.rd_data;
                     end else begin
                        pif.wr_en = 1'b1;
                        if (st_ff.f_op == OP_ACCU_TO_AXIS_PARAM_INDEXED) begin
                           pif.wr_data = st_ff.accu;
                        end
                     end
                  end
                  default: begin
                     exec_status = ST_BAD_CMD;
                  end
               endcase
            end
            if (st_ff.f_op != OP_GET_AXIS_PARAM_INDEXED || exec_status != ST_OK) begin
               nxt_st.reply_value = 32'h0;
            end
            nxt_st.reply_valid  = 1'b1;
            nxt_st.reply_status = exec_status;
            nxt_st.reply_op     = st_ff.f_op;
            nxt_st.last_status  = exec_status;
            nxt_st.cmd_cnt      = st_ff.cmd_cnt + 16'h1;
         end
         FSM_REPLY: begin
            nxt_st.fsm = FSM_RECV;
         end
         default: begin
            nxt_st.fsm = FSM_RECV;
         end
      endcase
      if (pif.wr_en) begin
         nxt_st.mc_update = 1'b1;
         nxt_st.mc_axis   = pif.wr_axis;
         nxt_st.mc_param  = pif.wr_idx;
         nxt_st.mc_data   = pif.wr_data;
      end
      // Abort lets software resync after a lost byte; no timeout exists
      if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_ABORT_BIT] &&
          st_ff.fsm == FSM_RECV) begin
         nxt_st.cnt = 4'h0;
         nxt_st.sum = 8'h0;
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_ACCU: begin
               nxt_st.rdata = st_ff.accu;
            end
            REG_XREG: begin
               nxt_st.rdata = st_ff.xreg;
            end
            REG_STATUS: begin
               nxt_st.rdata[STATUS_LAST_ST_LSB +: 8] = st_ff.last_status;
               nxt_st.rdata[STATUS_LAST_OP_LSB +: 8] = st_ff.reply_op;
               nxt_st.rdata[STATUS_FSM_LSB +: 2]     = st_ff.fsm;
            end
            REG_CMD_COUNT: begin
               nxt_st.rdata[15:0] = st_ff.cmd_cnt;
            end
            default: begin
               nxt_st.rdata = 32'h0;
            end
         endcase
      end
      nxt_st.rx_ready = (nxt_st.fsm == FSM_RECV);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_ff              <= '0;
         st_ff.fsm          <= FSM_RECV;
         st_ff.accu         <= ACCU_RST;
         st_ff.xreg         <= XREG_RST;
         st_ff.cmd_cnt      <= CMD_COUNT_RST;
         st_ff.rx_ready     <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rx_ready      = st_ff.rx_ready;
   assign reply_valid   = st_ff.reply_valid;
   assign reply_status  = st_ff.reply_status;
   assign reply_opcode  = st_ff.reply_op;
   assign reply_value   = st_ff.reply_value;
   assign reg_rdata     = st_ff.rdata;
   assign mc_update     = st_ff.mc_update;
   assign mc_axis       = st_ff.mc_axis;
   assign mc_param      = st_ff.mc_param;
   assign mc_data       = st_ff.mc_data;
   assign axis_vel_mode = st_ff.vel_mode;
   assign axis_dir_up   = st_ff.dir_up;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // Plain signal, so it can be combined with other terms by a logical and
   logic exec_ok;
   assign exec_ok = st_ff.fsm == FSM_EXEC && st_ff.csum_ok && axis_ok(st_ff.xreg);
   property p_rotate;
      exec_ok && st_ff.f_op == OP_ROTATE_RIGHT_INDEXED
      |=> mc_update && mc_param == PAR_TARGET_VEL[PW-1:0] &&
          axis_vel_mode[mc_axis] && axis_dir_up[mc_axis];
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate did not load target velocity");
   property p_vel_unscaled;
      exec_ok && st_ff.f_op == OP_ROTATE_RIGHT_INDEXED |=> mc_data == $past(st_ff.accu);
   endproperty
   a_vel_unscaled: assert property (p_vel_unscaled)
      else $error("rotate velocity altered");
   property p_axis_from_x;
      st_ff.fsm == FSM_EXEC && pif.wr_en |=> mc_axis == $past(st_ff.xreg[AW-1:0]);
   endproperty
   a_axis_from_x: assert property (p_axis_from_x)
      else $error("axis not taken from X register");
   property p_stop;
      exec_ok && st_ff.f_op == OP_SOFT_STOP_INDEXED
      |=> mc_update && mc_data == 32'h0 && axis_vel_mode[mc_axis];
   endproperty
   a_stop: assert property (p_stop)
      else $error("soft stop did not zero target speed");
   property p_set;
      exec_ok && st_ff.f_op == OP_SET_AXIS_PARAM_INDEXED && st_ff.f_type < NP8
      |=> mc_data == $past(st_ff.f_val) && 8'(mc_param) == $past(st_ff.f_type);
   endproperty
   a_set: assert property (p_set)
      else $error("indexed set wrote wrong value");
   property p_get_accu;
      exec_ok && st_ff.f_op == OP_GET_AXIS_PARAM_INDEXED && st_ff.f_type < NP8
      |=> st_ff.accu == $past(pif.rd_data) && !mc_update;
   endproperty
   a_get_accu: assert property (p_get_accu)
      else $error("indexed get did not load accumulator");
   property p_get_reply;
      exec_ok && st_ff.f_op == OP_GET_AXIS_PARAM_INDEXED && st_ff.f_type < NP8
      |=> reply_status == ST_OK && reply_value == $past(pif.rd_data);
   endproperty
   a_get_reply: assert property (p_get_reply)
      else $error("indexed get reply wrong");
   property p_accu_param;
      exec_ok && st_ff.f_op == OP_ACCU_TO_AXIS_PARAM_INDEXED && st_ff.f_type < NP8
      |=> mc_update && mc_data == $past(st_ff.accu);
   endproperty
   a_accu_param: assert property (p_accu_param)
      else $error("accumulator not written to parameter");
   property p_ok_reply;
      reply_valid && reply_opcode != OP_GET_AXIS_PARAM_INDEXED && reply_status == ST_OK
      |-> reply_value == 32'h0 && mc_update;
   endproperty
   a_ok_reply: assert property (p_ok_reply)
      else $error("write command reply inconsistent");
   property p_act_pos;
      exec_ok && st_ff.f_op == OP_GET_AXIS_PARAM_INDEXED && st_ff.f_type == PAR_ACT_POS
      |=> reply_value == $past(axis_pos(act_pos, x_axis));
   endproperty
   a_act_pos: assert property (p_act_pos)
      else $error("actual position not returned");
   property p_bad_sum;
      st_ff.fsm == FSM_RECV && rx_valid && st_ff.cnt == FRAME_LAST &&
      st_ff.f_addr == MODULE_ADDR && rx_byte != st_ff.sum
      |=> ##1 reply_valid && reply_status == ST_BAD_CHECKSUM && !mc_update;
   endproperty
   a_bad_sum: assert property (p_bad_sum)
      else $error("bad checksum not refused");
   property p_one_reply;
      reply_valid |-> $past(st_ff.fsm) == FSM_EXEC ##1 !reply_valid [*2];
   endproperty
   a_one_reply: assert property (p_one_reply)
      else $error("reply not single");
   property p_frame_len;
      st_ff.fsm == FSM_RECV && rx_valid && st_ff.cnt == FRAME_LAST &&
      st_ff.f_addr == MODULE_ADDR |=> ##1 reply_valid;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("nine-byte frame not answered");
   c_rotate:  cover property ((exec_ok && st_ff.f_op == OP_ROTATE_RIGHT_INDEXED) ##1 mc_update);
   c_stop:    cover property ((exec_ok && st_ff.f_op == OP_SOFT_STOP_INDEXED) ##1 mc_update);
   c_get:     cover property ((exec_ok && st_ff.f_op == OP_GET_AXIS_PARAM_INDEXED) ##1 reply_valid);
   c_bad_sum: cover property (reply_valid && reply_status == ST_BAD_CHECKSUM);
endmodule : xace_cmd_exec
`default_nettype wire

//--- verif/xace_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module xace_host_model (
   input  wire logic       clk,
   input  wire logic       rx_ready,
   output logic            rx_valid,
   output logic [7:0]      rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
   end

   // Sends one frame; bad adds an offset to the checksum byte
   task automatic send(input logic [7:0] addr, input logic [7:0] op, input logic [7:0] typ,
                       input logic [7:0] bank, input logic [31:0] val, input logic [7:0] bad);
      logic [63:0] f;
      logic [7:0]  sum;
      logic [7:0]  b;
      f = {addr, op, typ, bank, val};
      sum = 8'h00;
      for (int i = 0; i < 8; i++) sum = sum + f[63-8*i -: 8];
      @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         b = (i < 8) ? f[63-8*i -: 8] : sum + bad;
         rx_valid <= 1'b1;
         rx_byte  <= b;
         @(posedge clk);
         while (rx_ready !== 1'b1) @(posedge clk);
      end
      rx_valid <= 1'b0;
      // Released line shows the inverse so a stale byte cannot pass
      rx_byte  <= ~b;
   endtask : send
endmodule : xace_host_model
`default_nettype wire

//--- verif/xreg_axis_command_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module xreg_axis_command_exec_tb
   import xace_pkg::*;
;
   logic        clk, reset, rx_valid, rx_ready, reply_valid, reg_wr, reg_rd, mc_update, upd;
   logic [7:0]  rx_byte, reply_status, reply_opcode, reg_addr;
   logic [31:0] reply_value, reg_wdata, reg_rdata, mc_data, rd_v;
   logic [95:0] act_pos;
   logic [1:0]  mc_axis;
   logic [3:0]  mc_param;
   logic [2:0]  axis_vel_mode, axis_dir_up;
   int          mismatches, num_checks;

   xace_host_model i_host (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
                           .rx_byte(rx_byte));
   xace_cmd_exec i_dut (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_ready(rx_ready), .reply_valid(reply_valid), .reply_status(reply_status),
      .reply_opcode(reply_opcode), .reply_value(reply_value), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .act_pos(act_pos), .mc_update(mc_update), .mc_axis(mc_axis), .mc_param(mc_param),
      .mc_data(mc_data), .axis_vel_mode(axis_vel_mode), .axis_dir_up(axis_dir_up));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // Sends a frame to this module and checks the single reply
   task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic [7:0] bad, input logic [7:0] st,
                      input logic [31:0] v);
      int n;
      i_host.send(MODULE_ADDR_RST, op, typ, bank, val, bad);
      upd = 1'b0;
      for (n = 0; n < 10; n++) begin
         @(posedge clk);
         #1;
         if (reply_valid === 1'b1) break;
      end
      upd = mc_update;
      chk("reply_valid", 32'h1, {31'h0, reply_valid});
      chk("rx_ready", 32'h0, {31'h0, rx_ready});
      chk("reply_status", {24'h0, st}, {24'h0, reply_status});
      chk("reply_opcode", {24'h0, op}, {24'h0, reply_opcode});
      chk("reply_value", v, reply_value);
   endtask : cmd

   task automatic mc(input logic [1:0] ax, input logic [7:0] par, input logic [31:0] d);
      chk("mc_update", 32'h1, {31'h0, upd});
      chk("mc_axis", {30'h0, ax}, {30'h0, mc_axis});
      chk("mc_param", {24'h0, par}, {28'h0, mc_param});
      chk("mc_data", d, mc_data);
   endtask : mc

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   initial begin
      #50000;
      mismatches++;
      finish_test();
   end

   initial begin
      int n;
      logic seen;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      act_pos = {32'h0000_0077, 32'h00ab_cdef, 32'h0000_0055};
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      wr(REG_XREG, 32'h2);
      wr(REG_ACCU, 32'h0000_1234);
      cmd(OP_ROTATE_RIGHT_INDEXED, 8'h00, 8'h05, 32'h0, 8'h0, ST_OK, 32'h0);
      mc(2'd2, PAR_TARGET_VEL, 32'h0000_1234);
      chk("vel_mode", 32'h4, {29'h0, axis_vel_mode});
      chk("dir_up", 32'h4, {29'h0, axis_dir_up});
      $display("test rotate done");
      wr(REG_XREG, 32'h1);
      cmd(OP_SOFT_STOP_INDEXED, 8'h00, 8'h02, 32'h0, 8'h0, ST_OK, 32'h0);
      mc(2'd1, PAR_TARGET_VEL, 32'h0);
      chk("vel_mode", 32'h6, {29'h0, axis_vel_mode});
      chk("dir_up", 32'h4, {29'h0, axis_dir_up});
      $display("test stop done");
      cmd(OP_SET_AXIS_PARAM_INDEXED, 8'h04, 8'h00, 32'h0000_c800, 8'h0, ST_OK, 32'h0);
      mc(2'd1, PAR_MAX_POS_SPEED, 32'h0000_c800);
      cmd(OP_GET_AXIS_PARAM_INDEXED, 8'h04, 8'h02, 32'h0, 8'h0, ST_OK, 32'h0000_c800);
      rd(REG_ACCU, rd_v);
      chk("accu", 32'h0000_c800, rd_v);
      cmd(OP_GET_AXIS_PARAM_INDEXED, 8'h01, 8'h00, 32'h0, 8'h0, ST_OK, 32'h00ab_cdef);
      rd(REG_ACCU, rd_v);
      chk("accu", 32'h00ab_cdef, rd_v);
      $display("test set get done");
      cmd(OP_ACCU_TO_AXIS_PARAM_INDEXED, 8'h03, 8'h01, 32'hffff_ffff, 8'h0, ST_OK, 32'h0);
      mc(2'd1, 8'h03, 32'h00ab_cdef);
      cmd(OP_SET_AXIS_PARAM_INDEXED, 8'h04, 8'h00, 32'h5, 8'h1, ST_BAD_CHECKSUM, 32'h0);
      chk("mc_update", 32'h0, {31'h0, upd});
      chk("mc_data", 32'h00ab_cdef, mc_data);
      rd(REG_STATUS, rd_v);
      chk("status", 32'h0000_1001, rd_v);
      $display("test accu checksum done");
      cmd(8'h34, 8'h00, 8'h00, 32'h0, 8'h0, ST_BAD_CMD, 32'h0);
      cmd(OP_GET_AXIS_PARAM_INDEXED, 8'h10, 8'h00, 32'h0, 8'h0, ST_BAD_TYPE, 32'h0);
      wr(REG_XREG, 32'h3);
      cmd(OP_ROTATE_RIGHT_INDEXED, 8'h00, 8'h00, 32'h0, 8'h0, ST_BAD_VALUE, 32'h0);
      chk("mc_update", 32'h0, {31'h0, upd});
      chk("vel_mode", 32'h6, {29'h0, axis_vel_mode});
      $display("test error status done");
      i_host.send(8'h02, OP_SOFT_STOP_INDEXED, 8'h00, 8'h00, 32'h0, 8'h0);
      seen = 1'b0;
      for (n = 0; n < 15; n++) begin
         @(posedge clk);
         #1;
         if (reply_valid === 1'b1) seen = 1'b1;
      end
      chk("foreign_reply", 32'h0, {31'h0, seen});
      rd(REG_CMD_COUNT, rd_v);
      chk("cmd_count", 32'ha, {16'h0, rd_v[15:0]});
      rd(8'h20, rd_v);
      chk("unmapped", 32'h0, rd_v);
      $display("test count done");
      finish_test();
   end
endmodule : xreg_axis_command_exec_tb
`default_nettype wire
